// ### logic/tmcc_regs.svh
// constants for the timer module common core
`ifndef TMCC_REGS_SVH
`define TMCC_REGS_SVH

// byte register select codes on i_reg_sel
`define TMCC_SEL_CNT_LO 3'h0
`define TMCC_SEL_CNT_HI 3'h1
`define TMCC_SEL_A_LO 3'h2
`define TMCC_SEL_A_HI 3'h3
`define TMCC_SEL_P_LO 3'h4
`define TMCC_SEL_P_HI 3'h5

// counter clock select codes
`define TMCC_CK_SYS_DIV4 3'h0
`define TMCC_CK_SYS 3'h1
`define TMCC_CK_FH_DIV16 3'h2
`define TMCC_CK_FH_DIV64 3'h3
`define TMCC_CK_SUB 3'h4
`define TMCC_CK_OFF 3'h5
`define TMCC_CK_EXT_RISE 3'h6
`define TMCC_CK_EXT_FALL 3'h7

// output action codes for compare match output mode
`define TMCC_IO_NONE 2'h0
`define TMCC_IO_LOW 2'h1
`define TMCC_IO_HIGH 2'h2
`define TMCC_IO_TOGGLE 2'h3

// pwm pin codes
`define TMCC_PWM_INACTIVE 2'h0
`define TMCC_PWM_ACTIVE 2'h1
`define TMCC_PWM_WAVE 2'h2

// capture edge codes
`define TMCC_CAP_RISE 2'h0
`define TMCC_CAP_FALL 2'h1
`define TMCC_CAP_BOTH 2'h2

// divider terminal counts and reset values
`define TMCC_DIV4_LAST 2'h3
`define TMCC_FH16_LAST 4'hf
`define TMCC_FH64_LAST 6'h3f
`define TMCC_RST_BYTE 8'h00
// core edges after reset before pin edges are trusted
`define TMCC_SYNC_SETTLE 3'h5

`endif

// ### logic/tmcc_pkg.sv
// types shared by the timer module common core
package tmcc_pkg;

  // operating modes of the timer
  typedef enum logic [2:0] {
    TMCC_MODE_CMP_OUT,
    TMCC_MODE_CAPTURE,
    TMCC_MODE_PWM,
    TMCC_MODE_TIMER,
    TMCC_MODE_PULSE
  } tmcc_mode_t;

endpackage

// ### logic/tmcc_pin_sync.sv
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps

module tmcc_pin_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } tmcc_sync_state_t;

  tmcc_sync_state_t s_q;
  tmcc_sync_state_t s_d;

  // shift chain; level follows only when stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.s1 = i_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.level[i] = s_q.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule

// ### logic/tmcc_core.sv
// timer module common core: counter, comparators, pins, byte access
`timescale 1ns/1ps
`include "tmcc_regs.svh"

// How it works
// - three-bit select picks the counter clock source
// - external pin clocks counter, rising or falling
// - compare match interrupts, may clear, may drive pin
// - separate interrupts for comparator A and P
// - compare match drives pin low, high or toggle
// - pwm waveform leaves on the timer output pin
// - capture mode turns output pin into input
// - inverted pin carries inverse of output while timer function selected
// - single pulse mode triggers from external pin
// - one bit picks timer or other pin function
// - wide registers split, low byte via buffer
// - compare low byte write fills buffer only
// - high byte write also moves buffer to low
// - high byte read latches low byte into buffer
// - low byte read returns the holding buffer
// - counter width ten or sixteen bits by type
// - second pin gives complementary pair via port bit
module tmcc_core
  import tmcc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // clock enables from the clock tree, same domain
  input wire logic i_fh_tick,
  input wire logic i_sub_tick,
  // timer configuration
  input wire logic [2:0] i_counter_clock_select,
  input wire logic i_enable,
  input wire logic i_pause,
  input wire tmcc_pkg::tmcc_mode_t i_mode,
  input wire logic [1:0] i_io_sel,
  input wire logic i_out_init,
  input wire logic i_out_pol,
  input wire logic i_clear_on_a,
  // pin sharing and complementary pair
  input wire logic i_pin_fn_sel,
  input wire logic i_alt_out,
  input wire logic i_alt_oe,
  input wire logic i_pair_invert,
  // pins
  input wire logic i_timer_clock_input_pin,
  input wire logic i_timer_output_pin,
  output logic o_timer_output_pin,
  output logic o_timer_output_pin_oe,
  output logic o_timer_output_pin_1,
  output logic o_inverted_timer_output_pin,
  // byte access port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_reg_sel,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // status
  output logic o_irq_a,
  output logic o_irq_p,
  output logic [CNT_W-1:0] o_count
);

  localparam int HI_W = CNT_W - 8;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_p;
    logic [7:0] hold;
    logic [1:0] div4;
    logic [5:0] fh_div;
    logic en_prev;
    logic ext_prev;
    logic cap_prev;
    logic [2:0] warm;
    logic out;
    logic pulse;
    logic irq_a;
    logic irq_p;
    logic [7:0] rd_data;
    logic rd_valid;
    logic pin_out;
    logic pin_oe;
    logic pin_1;
    logic pin_inv;
  } tmcc_core_state_t;

  tmcc_core_state_t s_q;
  tmcc_core_state_t s_d;

  logic ext_lvl;
  logic cap_lvl;

  // high byte of a wide value, zero extended to eight bits
  function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[HI_W-1:0] = v[CNT_W-1:8];
    return r;
  endfunction

  // join a written high byte with the buffered low byte
  function automatic logic [CNT_W-1:0] join_hi(input logic [7:0] hi,
                                               input logic [7:0] lo);
    return {hi[HI_W-1:0], lo};
  endfunction

  // both external pins pass the synchroniser
  tmcc_pin_sync #(
    .W(2)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin({i_timer_output_pin, i_timer_clock_input_pin}),
    .o_level({cap_lvl, ext_lvl})
  );

  // next-state logic
  always_comb begin
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic cap_edge;
    logic en_rise;
    logic tick;
    logic step;
    logic a_hit;
    logic p_hit;
    logic clr_hit;
    logic pin_val;
    logic drive;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    cap_edge = 1'b0;
    en_rise = 1'b0;
    tick = 1'b0;
    step = 1'b0;
    a_hit = 1'b0;
    p_hit = 1'b0;
    clr_hit = 1'b0;
    pin_val = 1'b0;
    drive = 1'b0;
    s_d = s_q;
    s_d.irq_a = 1'b0;
    s_d.irq_p = 1'b0;
    s_d.rd_valid = 1'b0;

    // edge detection on filtered pin levels and on enable
    ext_rise = ext_lvl & ~s_q.ext_prev;
    ext_fall = ~ext_lvl & s_q.ext_prev;
    cap_rise = cap_lvl & ~s_q.cap_prev;
    cap_fall = ~cap_lvl & s_q.cap_prev;
    en_rise = i_enable & ~s_q.en_prev;
    s_d.ext_prev = ext_lvl;
    s_d.cap_prev = cap_lvl;
    s_d.en_prev = i_enable;

    // no pin edges until the synchroniser holds real pin levels
    if (s_q.warm != `TMCC_SYNC_SETTLE) begin
      s_d.warm = s_q.warm + 3'h1;
      ext_rise = 1'b0;
      ext_fall = 1'b0;
      cap_rise = 1'b0;
      cap_fall = 1'b0;
    end

    // prescalers for the system and high clocks
    s_d.div4 = s_q.div4 + 2'h1;
    if (i_fh_tick) begin
      s_d.fh_div = s_q.fh_div + 6'h01;
    end

    // counter clock source selection
    unique case (i_counter_clock_select)
      `TMCC_CK_SYS_DIV4: tick = (s_q.div4 == `TMCC_DIV4_LAST);
      `TMCC_CK_SYS: tick = 1'b1;
      `TMCC_CK_FH_DIV16:
        tick = i_fh_tick && (s_q.fh_div[3:0] == `TMCC_FH16_LAST);
      `TMCC_CK_FH_DIV64:
        tick = i_fh_tick && (s_q.fh_div == `TMCC_FH64_LAST);
      `TMCC_CK_SUB: tick = i_sub_tick;
      `TMCC_CK_OFF: tick = 1'b0;
      `TMCC_CK_EXT_RISE: tick = ext_rise;
      `TMCC_CK_EXT_FALL: tick = ext_fall;
    endcase

    // counter: cleared on enable rise, steps on each active tick
    step = i_enable && !i_pause && tick && !en_rise;
    a_hit = step && (s_q.cnt == s_q.cmp_a);
    p_hit = step && (s_q.cnt == s_q.cmp_p);
    clr_hit = i_clear_on_a ? a_hit : p_hit;
    if (en_rise) begin
      s_d.cnt = '0;
    end else if (step) begin
      if (clr_hit) begin
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end

    // one interrupt pulse per comparator
    s_d.irq_a = a_hit && (i_mode != TMCC_MODE_CAPTURE);
    s_d.irq_p = p_hit;

    // byte access: low bytes go through the shared holding buffer
    if (i_wr) begin
      unique case (i_reg_sel)
        `TMCC_SEL_A_LO, `TMCC_SEL_P_LO: begin
          s_d.hold = i_wr_data;
        end
        `TMCC_SEL_A_HI: begin
          s_d.cmp_a = join_hi(i_wr_data, s_q.hold);
        end
        `TMCC_SEL_P_HI: begin
          s_d.cmp_p = join_hi(i_wr_data, s_q.hold);
        end
        default: begin
          // counter bytes are read only
        end
      endcase
    end
    if (i_rd) begin
      s_d.rd_valid = 1'b1;
      unique case (i_reg_sel)
        `TMCC_SEL_CNT_HI: begin
          s_d.rd_data = hi_byte(s_q.cnt);
          s_d.hold = s_q.cnt[7:0];
        end
        `TMCC_SEL_A_HI: begin
          s_d.rd_data = hi_byte(s_q.cmp_a);
          s_d.hold = s_q.cmp_a[7:0];
        end
        `TMCC_SEL_P_HI: begin
          s_d.rd_data = hi_byte(s_q.cmp_p);
          s_d.hold = s_q.cmp_p[7:0];
        end
        `TMCC_SEL_CNT_LO, `TMCC_SEL_A_LO, `TMCC_SEL_P_LO: begin
          s_d.rd_data = s_q.hold;
        end
        default: begin
          s_d.rd_data = `TMCC_RST_BYTE;
        end
      endcase
    end

    // output behaviour per operating mode
    unique case (i_mode)
      TMCC_MODE_CMP_OUT: begin
        if (en_rise) begin
          s_d.out = i_out_init;
        end else if (a_hit) begin
          unique case (i_io_sel)
            `TMCC_IO_NONE: s_d.out = s_q.out;
            `TMCC_IO_LOW: s_d.out = 1'b0;
            `TMCC_IO_HIGH: s_d.out = 1'b1;
            `TMCC_IO_TOGGLE: s_d.out = ~s_q.out;
          endcase
        end
        drive = 1'b1;
      end
      TMCC_MODE_PWM: begin
        unique case (i_io_sel)
          `TMCC_PWM_INACTIVE: s_d.out = 1'b0;
          `TMCC_PWM_ACTIVE: s_d.out = 1'b1;
          `TMCC_PWM_WAVE: s_d.out = (s_d.cnt < s_q.cmp_a);
          default: s_d.out = s_q.out;
        endcase
        drive = 1'b1;
      end
      TMCC_MODE_PULSE: begin
        // pulse starts on enable rise or pin trigger, ends on A match
        if (a_hit) begin
          s_d.pulse = 1'b0;
        end
        if (i_enable && (en_rise || ext_rise)) begin
          s_d.pulse = 1'b1;
        end
        if (!i_enable) begin
          s_d.pulse = 1'b0;
        end
        s_d.out = s_d.pulse;
        drive = 1'b1;
      end
      TMCC_MODE_CAPTURE: begin
        // pin is an input; its edge latches the counter into A
        unique case (i_io_sel)
          `TMCC_CAP_RISE: cap_edge = cap_rise;
          `TMCC_CAP_FALL: cap_edge = cap_fall;
          `TMCC_CAP_BOTH: cap_edge = cap_rise | cap_fall;
          default: cap_edge = 1'b0;
        endcase
        if (i_enable && cap_edge) begin
          s_d.cmp_a = s_q.cnt;
          s_d.irq_a = 1'b1;
        end
        s_d.out = 1'b0;
        drive = 1'b0;
      end
      TMCC_MODE_TIMER: begin
        s_d.out = 1'b0;
        drive = 1'b0;
      end
      default: begin
        s_d.out = s_q.out;
        drive = 1'b0;
      end
    endcase

    // pin muxing, polarity and the derived pins
    pin_val = s_d.out ^ i_out_pol;
    if (i_pin_fn_sel) begin
      s_d.pin_out = pin_val;
      s_d.pin_oe = drive;
    end else begin
      s_d.pin_out = i_alt_out;
      s_d.pin_oe = i_alt_oe;
    end
    s_d.pin_inv = ~pin_val;
    s_d.pin_1 = pin_val ^ i_pair_invert;
  end

  // state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.pin_inv <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_timer_output_pin = s_q.pin_out;
  assign o_timer_output_pin_oe = s_q.pin_oe;
  assign o_timer_output_pin_1 = s_q.pin_1;
  assign o_inverted_timer_output_pin = s_q.pin_inv;
  assign o_rd_data = s_q.rd_data;
  assign o_rd_valid = s_q.rd_valid;
  assign o_irq_a = s_q.irq_a;
  assign o_irq_p = s_q.irq_p;
  assign o_count = s_q.cnt;

endmodule

// ### bench/tmcc_core_asserts.sv
// assertion checker for the timer common core ports
`timescale 1ns/1ps
module tmcc_core_chk
  import tmcc_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_counter_clock_select,
  input wire logic i_enable,
  input wire logic i_pause,
  input wire tmcc_pkg::tmcc_mode_t i_mode,
  input wire logic i_clear_on_a,
  input wire logic i_pin_fn_sel,
  input wire logic i_rd,
  input wire logic [2:0] i_reg_sel,
  input wire logic o_timer_output_pin,
  input wire logic o_timer_output_pin_oe,
  input wire logic o_inverted_timer_output_pin,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic o_irq_a,
  input wire logic [CNT_W-1:0] o_count
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // pin pair, read port, counter and capture pin enable relations
  a_inv_pin_pair: assert property (
    $past(i_pin_fn_sel) |->
    o_inverted_timer_output_pin != o_timer_output_pin)
    else $error("inverted pin equals main pin");
  a_rd_valid_lag: assert property (
    o_rd_valid == $past(i_rd))
    else $error("read valid not one cycle after read");
  a_rd_hi_byte: assert property (
    i_rd && i_reg_sel == 3'h1 |=>
    o_rd_data == 8'($past(o_count) >> 8))
    else $error("counter high byte read wrong");
  a_rd_lo_buffer: assert property (
    i_rd && i_reg_sel == 3'h1 ##1 i_rd && i_reg_sel == 3'h0 |=>
    o_rd_data == 8'($past(o_count, 2)))
    else $error("low byte read not from buffer");
  a_hold_no_tick: assert property (
    ((i_pause && $past(i_pause)) || (i_counter_clock_select == 3'h5 &&
    $past(i_counter_clock_select) == 3'h5)) && i_enable && $past(i_enable)
    |=> $stable(o_count))
    else $error("counter moved without tick");
  a_sys_step: assert property (
    i_counter_clock_select == 3'h1 && $past(i_counter_clock_select) == 3'h1
    && i_enable && $past(i_enable) && !i_pause && !$past(i_pause) |=>
    o_count == CNT_W'($past(o_count) + 1'b1) || o_count == '0)
    else $error("counter step wrong");
  a_clear_on_a: assert property (
    o_irq_a && $past(i_clear_on_a) && $past(i_mode) != TMCC_MODE_CAPTURE
    |-> o_count == '0)
    else $error("match a did not clear counter");
  a_capture_oe: assert property (
    $past(i_mode) == TMCC_MODE_CAPTURE && $past(i_pin_fn_sel) |->
    !o_timer_output_pin_oe)
    else $error("pin driven in capture mode");
endmodule

bind tmcc_core tmcc_core_chk #(.CNT_W(CNT_W)) i_chk (.*);

// ### bench/tmcc_pin_model.sv
// far-side pins: external clock source and output pin wire
`timescale 1ns/1ps
module tmcc_pin_model (
  input wire logic i_oe,
  input wire logic i_drv,
  output logic o_ck_pin,
  output logic o_wire
);
  logic ext_lo;
  // released pin is pulled high unless held low from outside
  assign o_wire = i_oe ? i_drv : !ext_lo;
  initial begin
    o_ck_pin = 1'b0;
    ext_lo = 1'b0;
  end
  // outside driver on the released output pin
  task automatic hold_low(input logic v);
    ext_lo = v;
  endtask
  // slow pulses so the pin filter sees every level
  task automatic pulse(input int n);
    repeat (n) begin
      #600 o_ck_pin = 1'b1;
      #600 o_ck_pin = 1'b0;
    end
  endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the timer common core
`timescale 1ns/1ps
`include "tmcc_regs.svh"
module testbench;
  import tmcc_pkg::*;
  logic clk = 0, rst = 1, fh = 1, sub = 0, en = 0, pau = 0, ini = 0;
  logic pol = 0, clra = 1, fns = 1, ao = 0, aoe = 0, pr = 0, wr = 0;
  logic rd = 0, ckp, pw, po, poe, p1, pn, rv, ia, ip;
  logic [2:0] cks = 3'h1, rs = 3'h0;
  logic [1:0] io = 2'h0;
  logic [7:0] wd = 8'h00, rdd;
  logic [9:0] cnt;
  tmcc_mode_t md = TMCC_MODE_TIMER;
  int bad_count = 0, total_checks = 0;
  // core clock and a sub clock enable every other cycle
  always #50 clk = ~clk;
  always @(negedge clk) sub <= ~sub;
  tmcc_core i_tmcc_core (.i_core_clk(clk), .i_rst(rst), .i_fh_tick(fh),
    .i_sub_tick(sub), .i_counter_clock_select(cks), .i_enable(en),
    .i_pause(pau), .i_mode(md), .i_io_sel(io), .i_out_init(ini),
    .i_out_pol(pol), .i_clear_on_a(clra), .i_pin_fn_sel(fns),
    .i_alt_out(ao), .i_alt_oe(aoe), .i_pair_invert(pr),
    .i_timer_clock_input_pin(ckp), .i_timer_output_pin(pw),
    .o_timer_output_pin(po), .o_timer_output_pin_oe(poe),
    .o_timer_output_pin_1(p1), .o_inverted_timer_output_pin(pn),
    .i_wr(wr), .i_rd(rd), .i_reg_sel(rs), .i_wr_data(wd),
    .o_rd_data(rdd), .o_rd_valid(rv), .o_irq_a(ia), .o_irq_p(ip),
    .o_count(cnt));
  tmcc_pin_model i_tmcc_pin_model (.i_oe(poe), .i_drv(po),
    .o_ck_pin(ckp), .o_wire(pw));
  // verdict and end of run
  task end_of_test;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one byte access per cycle, strobes left up for back to back use
  task acc(input logic w, input logic [2:0] s, input logic [7:0] d);
    wr = w;
    rd = !w;
    rs = s;
    wd = d;
    @(negedge clk);
    if (!w) begin
      chk(rv, 1);
      chk(rdd, d);
    end
  endtask
  task idle;
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask
  task setcmp(input logic [2:0] s, input logic [9:0] v);
    acc(1, s, v[7:0]);
    acc(1, s + 3'h1, {6'h00, v[9:8]});
    idle;
  endtask
  // bounded wait for irq a, irq p or the pin going high
  task wait_for(input int w);
    for (int k = 0; (w == 0 ? ia : w == 1 ? ip : po) !== 1'b1; k++) begin
      if (k == 200) begin
        bad_count++;
        end_of_test;
      end
      @(negedge clk);
    end
  endtask
  // byte access through the holding buffer
  task t_bytes;
    acc(1, `TMCC_SEL_A_LO, 8'h5a);
    acc(0, `TMCC_SEL_A_HI, 8'h00);
    acc(0, `TMCC_SEL_A_LO, 8'h00);
    acc(1, `TMCC_SEL_A_LO, 8'h5a);
    acc(1, `TMCC_SEL_A_HI, 8'h01);
    acc(1, `TMCC_SEL_P_LO, 8'h3c);
    acc(1, `TMCC_SEL_P_HI, 8'h02);
    acc(1, `TMCC_SEL_CNT_HI, 8'h03);
    acc(0, `TMCC_SEL_A_HI, 8'h01);
    acc(0, `TMCC_SEL_A_LO, 8'h5a);
    acc(0, `TMCC_SEL_P_HI, 8'h02);
    acc(0, `TMCC_SEL_P_LO, 8'h3c);
    acc(0, `TMCC_SEL_CNT_HI, 8'h00);
    acc(0, 3'h6, 8'h00);
    idle;
  endtask
  // match periods, interrupts, pause and counter read
  task t_count;
    logic [9:0] v;
    setcmp(`TMCC_SEL_A_LO, 10'h002);
    setcmp(`TMCC_SEL_P_LO, 10'h3ff);
    en = 1;
    wait_for(0);
    for (int k = 0; k < 9; k++) begin
      chk(cnt, k % 3);
      chk(ia, k % 3 == 0);
      chk(ip, 0);
      cyc(1);
    end
    clra = 0;
    setcmp(`TMCC_SEL_P_LO, 10'h004);
    wait_for(1);
    for (int k = 0; k < 10; k++) begin
      chk(cnt, k % 5);
      chk(ip, k % 5 == 0);
      chk(ia, k % 5 == 3);
      cyc(1);
    end
    pau = 1;
    cyc(2);
    v = cnt;
    cyc(5);
    chk(cnt, v);
    acc(0, `TMCC_SEL_CNT_HI, 8'h00);
    acc(0, `TMCC_SEL_CNT_LO, v[7:0]);
    idle;
    pau = 0;
  endtask
  // tick rate of each internal clock choice except the system clock over 64 cycles
  task automatic t_clk;
    logic [2:0] sel[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    int e[5] = '{16, 4, 1, 32, 0};
    setcmp(`TMCC_SEL_P_LO, 10'h3ff);
    for (int k = 0; k < 5; k++) begin
      en = 0;
      cks = sel[k];
      cyc(1);
      en = 1;
      cyc(65);
      chk(cnt + 1 >= e[k] && cnt <= e[k] + 1, 1);
    end
  endtask
  // external pin as counter clock, both edges
  task t_ext;
    for (int f = 0; f < 2; f++) begin
      en = 0;
      cks = f ? `TMCC_CK_EXT_FALL : `TMCC_CK_EXT_RISE;
      cyc(1);
      en = 1;
      cyc(2);
      i_tmcc_pin_model.pulse(5);
      cyc(8);
      chk(cnt, 5);
    end
  endtask
  // output actions, pwm, pin sharing, capture and single pulse
  task t_out;
    int n;
    md = TMCC_MODE_CMP_OUT;
    cks = `TMCC_CK_SYS;
    clra = 1;
    pr = 1;
    for (int k = 0; k < 4; k++) begin
      en = 0;
      io = 2'(k);
      ini = k < 2;
      cyc(1);
      en = 1;
      wait_for(0);
      chk(po, k != 1);
      chk(pn, k == 1);
      chk(p1, k == 1);
    end
    cyc(1);
    wait_for(0);
    chk(po, 0);
    md = TMCC_MODE_PWM;
    io = `TMCC_PWM_WAVE;
    cyc(6);
    n = 0;
    repeat (30) begin
      n += po;
      cyc(1);
    end
    chk(n, 20);
    io = `TMCC_PWM_ACTIVE;
    cyc(2);
    chk(po, 1);
    io = `TMCC_PWM_INACTIVE;
    pol = 1;
    cyc(2);
    chk({po, pn}, 2'h2);
    pol = 0;
    fns = 0;
    aoe = 1;
    cyc(2);
    chk({po, poe}, 2'h1);
    ao = 1;
    aoe = 0;
    cyc(2);
    chk({po, poe}, 2'h2);
    fns = 1;
    md = TMCC_MODE_CAPTURE;
    io = `TMCC_CAP_RISE;
    cyc(2);
    chk(poe, 0);
    md = TMCC_MODE_PULSE;
    en = 0;
    cyc(1);
    en = 1;
    cyc(10);
    chk(po, 0);
    fork
      i_tmcc_pin_model.pulse(1);
      wait_for(2);
    join
  endtask
  // capture: an outside edge on the released pin latches the count in A
  task automatic t_cap;
    logic [9:0] v;
    logic [1:0] ed[3] = '{`TMCC_CAP_FALL, `TMCC_CAP_RISE, `TMCC_CAP_BOTH};
    md = TMCC_MODE_CAPTURE;
    clra = 0;
    for (int e = 0; e < 3; e++) begin
      io = ed[e];
      cyc(8);
      chk(ia, 0);
      i_tmcc_pin_model.hold_low(e != 1);
      wait_for(0);
      v = cnt - 10'h001;
      chk(poe, 0);
      acc(0, `TMCC_SEL_A_HI, {6'h00, v[9:8]});
      acc(0, `TMCC_SEL_A_LO, v[7:0]);
      idle;
    end
  endtask
  // main sequence
  initial begin
    cyc(20);
    rst = 0;
    chk(pn, 1);
    t_bytes;
    t_count;
    t_clk;
    t_ext;
    t_out;
    t_cap;
    end_of_test;
  end
endmodule
